// ===== clock_power_pkg.sv
// Constants, types and register map of the clock and power control block.
// Assumes one oscillator clock and a plain register port of 8-bit words.
//
// Notes on behaviour
// - Nonvolatile bit or bit0 selects 6-clock CPU
// - Fast CPU: each peripheral bit picks 6/12
// - Slow CPU: all peripherals run at 12
// - Serial divider only serves fixed modes 0,2
// - Reset needs two machine cycles held high
// - Ports 1-3 reset without waiting for clock
// - Access select pin latched at reset release
// - Idle halts CPU, peripherals keep running
// - Idle exits on interrupt or hardware reset
// - Power-down stops oscillator, state is kept
// - Power-down exits by reset or external interrupt
// - Low level irq pin wakes, high completes
// - Power-on flag set at power-up, software writable
// - Reset ending idle blocks RAM, not ports
// - Low strobe at reset release enters float mode
// - Clock-out needs internal source, enable, run bit
// - Clock-out is fosc over n times reload span
// - Clock-out overflows raise no interrupt
// - Strobes 1 in idle, 0 in power-down
`default_nettype none
package clock_power_pkg;
  // ==========================================================
  // Register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] OFF_CLK_DIV_CTRL = 4'h0;
  localparam logic [3:0] OFF_POWER_CTRL   = 4'h1;
  localparam logic [3:0] OFF_TC_CTRL      = 4'h2;
  localparam logic [3:0] OFF_TC_MODE      = 4'h3;
  localparam logic [3:0] OFF_TC_RELOAD_LO = 4'h4;
  localparam logic [3:0] OFF_TC_RELOAD_HI = 4'h5;
  localparam logic [3:0] OFF_STATUS       = 4'h6;
  // ==========================================================
  // Field positions
  localparam int unsigned CDC_CPU_FAST = 0;
  localparam int unsigned CDC_TIMER_A  = 1;
  localparam int unsigned CDC_TIMER_B  = 2;
  localparam int unsigned CDC_TIMER_C  = 3;
  localparam int unsigned CDC_SERIAL   = 4;
  localparam int unsigned CDC_COUNTER  = 5;
  localparam int unsigned CDC_WATCHDOG = 6;
  localparam int unsigned PC_IDLE      = 0;
  localparam int unsigned PC_PDOWN     = 1;
  localparam int unsigned PC_POF       = 4;
  localparam int unsigned TC_SOURCE    = 1;
  localparam int unsigned TC_RUN       = 2;
  localparam int unsigned TM_CLKOUT_EN = 1;
  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] CDC_RESET = 8'h00;
  localparam logic [7:0] CDC_MASK  = 8'h7F;
  localparam logic [7:0] PC_RESET  = 8'h00;
  localparam logic [7:0] PC_MASK   = 8'h13;
  localparam logic [7:0] TC_RESET  = 8'h00;
  localparam logic [7:0] TM_RESET  = 8'h00;
  localparam logic [7:0] TM_MASK   = 8'h03;
  localparam logic [7:0] REG_ZERO  = 8'h00;
  localparam logic [15:0] TC_TOP   = 16'hFFFF;
  // ==========================================================
  // Timing
  localparam int unsigned FAST_DIV = 6;
  localparam int unsigned SLOW_DIV = 12;
  localparam logic [1:0] RESET_MACHINE_CYCLES = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    ST_RUN  = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_PDWN = 5'b00100,
    ST_WAKE = 5'b01000,
    ST_EMU  = 5'b10000
  } power_state_t;
  typedef struct packed {
    logic fast;
    logic slow;
    logic half;
  } divider_ticks_t;
  typedef struct packed {
    logic watchdog;
    logic counter_array;
    logic serial;
    logic timer_c;
    logic timer_b;
    logic timer_a;
  } periph_ticks_t;
  typedef struct packed {
    logic hold;
    logic level;
    logic port0_float;
    logic port2_address;
    logic weak_pullup;
  } strobe_pins_t;
endpackage : clock_power_pkg
`default_nettype wire

// ===== tick_divider.sv
// Divide-by-6, divide-by-12 and divide-by-2 tick enables.
// Assumes the oscillator clock; run_i low freezes the count.
`default_nettype none
module tick_divider #(
  parameter int unsigned SLOW = clock_power_pkg::SLOW_DIV
) (
  input  wire logic                            mclk_i,
  input  wire logic                            rst_i,
  input  wire logic                            run_i,
  output var  clock_power_pkg::divider_ticks_t ticks_o
);
  import clock_power_pkg::*;
  // Elaboration check: the 4-bit count serves only twice FAST_DIV
  if (SLOW != 2 * FAST_DIV || SLOW > 15) begin : g_bad_slow
    $error("tick_divider: SLOW must be twice FAST_DIV");
  end
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  wire        last_w = (cnt_reg == 4'(SLOW - 1));
  wire        mid_w  = (cnt_reg == 4'(FAST_DIV - 1));
  assign cnt_next = last_w ? 4'h0 : cnt_reg + 4'h1;
  // Count oscillator cycles and emit one-cycle enables
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 4'h0;
      ticks_o <= '0;
    end else if (run_i) begin
      cnt_reg      <= cnt_next;
      ticks_o.slow <= last_w;
      ticks_o.fast <= last_w | mid_w;
      ticks_o.half <= cnt_reg[0];
    end else begin
      ticks_o <= '0;
    end
  end
endmodule : tick_divider
`default_nettype wire

// ===== clock_power_control.sv
// Clock rate selection, power states, reset timing and clock-out.
// Assumes synchronous pins and a register port answering one
// cycle after the read strobe.
//
// Local design decisions: the register addresses and strobed register access.
`default_nettype none
module clock_power_control (
  input  wire logic                            mclk_i,
  input  wire logic                            rst_i,
  input  wire logic [clock_power_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [clock_power_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output var  logic [clock_power_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic                            nonvolatile_double_speed_bit_i,
  input  wire logic                            reset_pin_i,
  input  wire logic                            external_access_select_i,
  input  wire logic                            addr_latch_strobe_i,
  input  wire logic                            program_store_strobe_i,
  input  wire logic                            irq_pending_i,
  input  wire logic                            external_irq_a_pin_i,
  input  wire logic                            external_irq_b_pin_i,
  input  wire logic                            irq_a_wake_en_i,
  input  wire logic                            irq_b_wake_en_i,
  input  wire logic [1:0]                      serial_mode_i,
  output var  logic                            cpu_fast_o,
  output var  logic                            machine_cycle_tick_o,
  output var  clock_power_pkg::periph_ticks_t  periph_ticks_o,
  output var  logic                            internal_reset_o,
  output var  logic                            port_reset_o,
  output var  logic                            external_program_o,
  output var  logic                            cpu_halt_o,
  output var  logic                            osc_run_o,
  output var  logic                            ram_block_o,
  output var  clock_power_pkg::strobe_pins_t   strobes_o,
  output var  logic                            clock_out_o,
  output var  logic                            timer_c_irq_o,
  output var  logic                            baud_tick_o,
  output var  logic                            wake_irq_o
);
  import clock_power_pkg::*;

  // ==========================================================
  // Registers and state
  logic [7:0]     cdc_reg;
  logic [7:0]     pc_reg;
  logic [7:0]     tc_reg;
  logic [7:0]     tm_reg;
  logic [7:0]     rl_lo_reg;
  logic [7:0]     rl_hi_reg;
  logic [15:0]    tcnt_reg;
  logic [1:0]     rst_cnt_reg;
  logic           int_reset_reg;
  logic           ext_prog_reg;
  power_state_t   state_reg;
  power_state_t   state_next;
  divider_ticks_t div_w;
  periph_ticks_t  ticks_w;

  // ==========================================================
  // Tick generation
  tick_divider #(
    .SLOW (SLOW_DIV)
  ) u_div (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .run_i   (osc_run_o),
    .ticks_o (div_w)
  );

  // Rate selection per peripheral
  wire cpu_fast_w = nonvolatile_double_speed_bit_i
                  | cdc_reg[CDC_CPU_FAST];
  wire mc_tick_w  = cpu_fast_w ? div_w.fast : div_w.slow;

  function automatic logic pick_tick(input logic half_rate,
                                     input logic fast_cpu,
                                     input divider_ticks_t d);
    pick_tick = (fast_cpu && !half_rate) ? d.fast : d.slow;
  endfunction : pick_tick

  assign ticks_w.timer_a = pick_tick(cdc_reg[CDC_TIMER_A],
                                     cpu_fast_w, div_w);
  assign ticks_w.timer_b = pick_tick(cdc_reg[CDC_TIMER_B],
                                     cpu_fast_w, div_w);
  assign ticks_w.timer_c = pick_tick(cdc_reg[CDC_TIMER_C],
                                     cpu_fast_w, div_w);
  assign ticks_w.counter_array = pick_tick(cdc_reg[CDC_COUNTER],
                                     cpu_fast_w, div_w);
  assign ticks_w.watchdog = pick_tick(cdc_reg[CDC_WATCHDOG],
                                     cpu_fast_w, div_w);
  // Variable-rate serial modes take their rate from a timer
  assign ticks_w.serial = !serial_mode_i[0]
      && pick_tick(cdc_reg[CDC_SERIAL], cpu_fast_w, div_w);

  // ==========================================================
  // Reset pin timing
  // The first tick may come right after the pin rises: count one more
  wire rst_cnt_done_w = (rst_cnt_reg == RESET_MACHINE_CYCLES + 2'h1);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_cnt_reg   <= 2'h0;
      int_reset_reg <= 1'b1;
    end else if (!reset_pin_i) begin
      rst_cnt_reg   <= 2'h0;
      int_reset_reg <= 1'b0;
    end else if (mc_tick_w && !rst_cnt_done_w) begin
      rst_cnt_reg   <= rst_cnt_reg + 2'h1;
    end else if (rst_cnt_done_w) begin
      int_reset_reg <= 1'b1;
    end
  end
  wire reset_release_w = int_reset_reg && !reset_pin_i;

  // Ports follow the pin level with no clock edge in the path
  assign port_reset_o = reset_pin_i | int_reset_reg;

  // Strap capture at reset release
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_prog_reg <= 1'b0;
    end else if (reset_release_w) begin
      ext_prog_reg <= !external_access_select_i;
    end
  end

  // ==========================================================
  // Power state machine
  wire wake_low_w = (irq_a_wake_en_i && !external_irq_a_pin_i)
                  | (irq_b_wake_en_i && !external_irq_b_pin_i);
  wire emu_req_w  = !addr_latch_strobe_i && program_store_strobe_i;
  wire wr_pc_w    = reg_wr_i && (reg_addr_i == OFF_POWER_CTRL);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (pc_reg[PC_PDOWN]) begin
          state_next = ST_PDWN;
        end else if (pc_reg[PC_IDLE]) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending_i) begin
          state_next = ST_RUN;
        end
      end
      ST_PDWN: begin
        if (wake_low_w) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!wake_low_w) begin
          state_next = ST_RUN;
        end
      end
      ST_EMU: begin
        state_next = ST_EMU;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
    if (reset_release_w) begin
      state_next = emu_req_w ? ST_EMU : ST_RUN;
    end else if (int_reset_reg) begin
      state_next = ST_RUN;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Register writes
  wire wr_cdc_w = reg_wr_i && (reg_addr_i == OFF_CLK_DIV_CTRL);
  wire wr_tc_w  = reg_wr_i && (reg_addr_i == OFF_TC_CTRL);
  wire wr_tm_w  = reg_wr_i && (reg_addr_i == OFF_TC_MODE);
  wire wr_rll_w = reg_wr_i && (reg_addr_i == OFF_TC_RELOAD_LO);
  wire wr_rlh_w = reg_wr_i && (reg_addr_i == OFF_TC_RELOAD_HI);
  wire leave_w  = (state_reg != ST_RUN) && (state_next == ST_RUN);

  // Mode bits drop when the block returns to the run state
  logic [7:0] pc_next;
  always_comb begin
    pc_next = pc_reg;
    if (wr_pc_w) begin
      pc_next = reg_wdata_i & PC_MASK;
    end
    if (leave_w) begin
      pc_next[PC_IDLE]  = 1'b0;
      pc_next[PC_PDOWN] = 1'b0;
    end
  end

  // Internal reset reloads the control registers, not the flag
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cdc_reg   <= CDC_RESET;
      pc_reg    <= PC_RESET | (8'h01 << PC_POF);
      tc_reg    <= TC_RESET;
      tm_reg    <= TM_RESET;
      rl_lo_reg <= REG_ZERO;
      rl_hi_reg <= REG_ZERO;
    end else if (int_reset_reg) begin
      cdc_reg   <= CDC_RESET;
      pc_reg    <= (PC_RESET & ~(8'h01 << PC_POF))
                 | (pc_reg & (8'h01 << PC_POF));
      tc_reg    <= TC_RESET;
      tm_reg    <= TM_RESET;
      rl_lo_reg <= REG_ZERO;
      rl_hi_reg <= REG_ZERO;
    end else begin
      if (wr_cdc_w) cdc_reg <= reg_wdata_i & CDC_MASK;
      pc_reg <= pc_next;
      if (wr_tc_w) tc_reg <= reg_wdata_i;
      if (wr_tm_w) tm_reg <= reg_wdata_i & TM_MASK;
      if (wr_rll_w) rl_lo_reg <= reg_wdata_i;
      if (wr_rlh_w) rl_hi_reg <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Register reads
  wire [7:0] status_w = {3'h0, state_reg == ST_EMU, ext_prog_reg,
                         state_reg == ST_PDWN,
                         state_reg == ST_IDLE, cpu_fast_w};
  logic [7:0] rd_mux_w;
  always_comb begin
    unique case (reg_addr_i)
      OFF_CLK_DIV_CTRL: rd_mux_w = cdc_reg;
      OFF_POWER_CTRL:   rd_mux_w = pc_reg;
      OFF_TC_CTRL:      rd_mux_w = tc_reg;
      OFF_TC_MODE:      rd_mux_w = tm_reg;
      OFF_TC_RELOAD_LO: rd_mux_w = rl_lo_reg;
      OFF_TC_RELOAD_HI: rd_mux_w = rl_hi_reg;
      OFF_STATUS:       rd_mux_w = status_w;
      default:          rd_mux_w = REG_ZERO;
    endcase
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= REG_ZERO;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux_w : REG_ZERO;
    end
  end

  // ==========================================================
  // Timer C clock-out
  wire        run_w    = tc_reg[TC_RUN] && !tc_reg[TC_SOURCE];
  wire        clkout_w = run_w && tm_reg[TM_CLKOUT_EN];
  // Count every cycle when fast, every other when slow
  wire        co_step_w = cpu_fast_w ? osc_run_o : div_w.half;
  wire        tc_step_w = clkout_w ? co_step_w
                        : (run_w && ticks_w.timer_c);
  wire        tc_top_w  = (tcnt_reg == TC_TOP);
  wire [15:0] reload_w  = {rl_hi_reg, rl_lo_reg};
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tcnt_reg      <= 16'h0000;
      clock_out_o   <= 1'b0;
      timer_c_irq_o <= 1'b0;
      baud_tick_o   <= 1'b0;
    end else if (int_reset_reg || !run_w) begin
      tcnt_reg      <= reload_w;     // Stopped: preset so span is exact
      clock_out_o   <= 1'b0;
      timer_c_irq_o <= 1'b0;
      baud_tick_o   <= 1'b0;
    end else begin
      baud_tick_o   <= tc_step_w && tc_top_w;
      timer_c_irq_o <= tc_step_w && tc_top_w && !clkout_w;
      if (tc_step_w) begin
        tcnt_reg <= tc_top_w ? reload_w : tcnt_reg + 16'h0001;
        if (tc_top_w && clkout_w) begin
          clock_out_o <= !clock_out_o;
        end
      end
    end
  end

  // ==========================================================
  // Registered pin and status outputs
  wire in_idle_w = (state_next == ST_IDLE);
  wire in_pd_w   = (state_next == ST_PDWN);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_fast_o           <= 1'b0;
      machine_cycle_tick_o <= 1'b0;
      periph_ticks_o       <= '0;
      internal_reset_o     <= 1'b1;
      external_program_o   <= 1'b0;
      cpu_halt_o           <= 1'b0;
      osc_run_o            <= 1'b1;
      ram_block_o          <= 1'b0;
      strobes_o            <= '0;
      wake_irq_o           <= 1'b0;
    end else begin
      cpu_fast_o           <= cpu_fast_w;
      machine_cycle_tick_o <= mc_tick_w;
      periph_ticks_o       <= ticks_w;
      internal_reset_o     <= int_reset_reg;
      external_program_o   <= ext_prog_reg;
      cpu_halt_o <= in_idle_w | in_pd_w
                  | (state_next == ST_WAKE);
      osc_run_o  <= !in_pd_w || reset_pin_i;
      ram_block_o <= (state_reg == ST_IDLE)
                   && reset_pin_i;
      wake_irq_o <= (state_reg == ST_WAKE) && leave_w;
      strobes_o.hold  <= in_idle_w | in_pd_w;
      strobes_o.level <= in_idle_w;
      strobes_o.port0_float <= ((in_idle_w | in_pd_w) && ext_prog_reg)
                             || (state_next == ST_EMU);
      strobes_o.port2_address <= in_idle_w && ext_prog_reg;
      strobes_o.weak_pullup   <= (state_next == ST_EMU);
    end
  end

  // ==========================================================
  // Checks
  chk_fast_select: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 cpu_fast_o == $past(nonvolatile_double_speed_bit_i
                            | cdc_reg[CDC_CPU_FAST]))
    else $error("cpu rate mismatch");
  chk_fast_periph: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cpu_fast_w && !cdc_reg[CDC_TIMER_A])
      |-> ticks_w.timer_a == div_w.fast)
    else $error("fast peripheral rate wrong");
  chk_slow_periph: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cpu_fast_w |=> periph_ticks_o.watchdog == $past(div_w.slow))
    else $error("slow peripheral rate wrong");
  chk_serial_var: assert property (@(posedge mclk_i) disable iff (rst_i)
    serial_mode_i[0] |-> !ticks_w.serial)
    else $error("serial tick in variable mode");
  chk_reset_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(int_reset_reg) |-> $past(reset_pin_i, 11))
    else $error("reset taken too early");
  chk_strap_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !$past(reset_release_w) |-> $stable(ext_prog_reg))
    else $error("strap changed outside release");
  chk_idle_halt: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_reg == ST_IDLE) |-> cpu_halt_o && osc_run_o)
    else $error("idle not halting");
  chk_pd_osc: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_reg == ST_PDWN && !reset_pin_i && !wake_low_w)
      |=> !osc_run_o ##0 strobes_o.hold && !strobes_o.level)
    else $error("oscillator not stopped");
  chk_clkout_irq: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clkout_w && !int_reset_reg) |=> !timer_c_irq_o)
    else $error("clock-out raised interrupt");
  chk_ram_block: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_reg == ST_IDLE && reset_pin_i) |=> ram_block_o)
    else $error("ram not blocked");
  cov_idle_irq: cover property (@(posedge mclk_i) disable iff (rst_i)
    state_reg == ST_IDLE ##1 state_reg == ST_RUN);
  cov_pd_wake: cover property (@(posedge mclk_i) disable iff (rst_i)
    state_reg == ST_WAKE ##1 wake_irq_o);
  cov_emu: cover property (@(posedge mclk_i) disable iff (rst_i)
    state_reg == ST_EMU);
  cov_clkout: cover property (@(posedge mclk_i) disable iff (rst_i)
    $rose(clock_out_o));
endmodule : clock_power_control
`default_nettype wire

// ===== pin_partner.sv
// Model of the reset and wake pins driven from outside the block.
// Assumes the bench raises one-cycle requests just after a clock edge.
`default_nettype none
module pin_partner #(
  parameter int HOLD = 40
) (
  input  wire logic mclk_i,
  input  wire logic rst_req_i,
  input  wire logic wake_req_i,
  output var  logic reset_pin_o,
  output var  logic irq_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int rcnt = 0;
  int wcnt = 0;
  // ==========================================================
  // Pins idle low (reset) and high (wake) at time zero
  initial begin
    reset_pin_o = 1'b0;
    irq_pin_n_o = 1'b1;
  end
  // Stretch each request so the far side holds it long enough
  always @(posedge mclk_i) begin
    rcnt <= rst_req_i ? HOLD : (rcnt > 0 ? rcnt - 1 : 0);
    wcnt <= wake_req_i ? HOLD : (wcnt > 0 ? wcnt - 1 : 0);
    reset_pin_o <= rst_req_i || rcnt > 1;
    irq_pin_n_o <= !(wake_req_i || wcnt > 1);
  end
endmodule : pin_partner
`default_nettype wire

// ===== clock_power_control_tb.sv
// Self-checking bench of the clock and power control block.
// Assumes the package and the pin partner model are compiled first.
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  n_errors++; $display("BAD %0t %h vs %h", $time, a, e); end end
module clock_power_control_tb;
  import clock_power_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_i, reg_wr_i, reg_rd_i, nonvolatile_double_speed_bit_i;
  logic reset_pin_i, external_access_select_i, addr_latch_strobe_i;
  logic irq_pending_i, external_irq_a_pin_i, irq_a_wake_en_i;
  logic rst_req, wake_req, seen_irq;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] serial_mode_i;
  logic cpu_fast_o, machine_cycle_tick_o, internal_reset_o, port_reset_o;
  logic external_program_o, cpu_halt_o, osc_run_o, ram_block_o;
  logic clock_out_o, timer_c_irq_o, baud_tick_o, wake_irq_o;
  periph_ticks_t periph_ticks_o;
  strobe_pins_t strobes_o;
  logic [8:0] mon;
  int n_errors = 0;
  int total_checks = 0;
  int g;
  // ==========================================================
  // Design, far-side pins and observed pulse lines
  assign mon = {clock_out_o, baud_tick_o, machine_cycle_tick_o,
                periph_ticks_o};
  clock_power_control u_dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .nonvolatile_double_speed_bit_i,
    .reset_pin_i, .external_access_select_i, .addr_latch_strobe_i,
    .program_store_strobe_i(1'b1), .irq_pending_i, .external_irq_a_pin_i,
    .external_irq_b_pin_i(1'b1), .irq_a_wake_en_i, .irq_b_wake_en_i(1'b0),
    .serial_mode_i, .cpu_fast_o, .machine_cycle_tick_o, .periph_ticks_o,
    .internal_reset_o, .port_reset_o, .external_program_o, .cpu_halt_o,
    .osc_run_o, .ram_block_o, .strobes_o, .clock_out_o, .timer_c_irq_o,
    .baud_tick_o, .wake_irq_o);
  pin_partner u_pins (.mclk_i, .rst_req_i(rst_req), .wake_req_i(wake_req),
    .reset_pin_o(reset_pin_i), .irq_pin_n_o(external_irq_a_pin_i));
  // Clock and a sticky record of timer interrupts
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(negedge mclk_i) if (timer_c_irq_o === 1'b1) seen_irq <= 1'b1;
  // ==========================================================
  // Bus cycles, waits and pulse spacing
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge mclk_i) reg_wr_i <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge mclk_i) reg_rd_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e);
  endtask : rd_chk
  task wait_rel;
    for (int k = 0; k < 100 && internal_reset_o !== 1'b0; k++)
      @(negedge mclk_i);
    repeat (2) @(posedge mclk_i);
  endtask : wait_rel
  // Cycles between two rising edges of one line, 0 if none
  task gap(input int i, output int n);
    logic p;
    int r;
    p = 1'b1;
    r = 0;
    n = 0;
    for (int k = 0; k < 120 && r < 2; k++) begin
      @(negedge mclk_i);
      if (mon[i] === 1'b1 && p === 1'b0) r++;
      if (r == 1) n++;
      p = mon[i];
    end
    if (r < 2) n = 0;
  endtask : gap
  task end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #100000 n_errors++;
    end_sim();
  end
  // ==========================================================
  // Test sequence
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 15'h4000;
    {nonvolatile_double_speed_bit_i, irq_pending_i, irq_a_wake_en_i} = 3'h0;
    {external_access_select_i, addr_latch_strobe_i} = 2'h3;
    {rst_req, wake_req, seen_irq, serial_mode_i} = 5'h00;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    wait_rel();
    rd_chk(OFF_CLK_DIV_CTRL, CDC_RESET);
    rd_chk(OFF_POWER_CTRL, 8'h10);
    rd_chk(4'hF, REG_ZERO);
    wr_reg(OFF_POWER_CTRL, 8'h00);
    rd_chk(OFF_POWER_CTRL, 8'h00);
    // Slow CPU ticks every 12 with the bits clear, fast CPU honours each
    gap(6, g); `CHK(g, 12);
    gap(1, g); `CHK(g, 12);
    for (int b = 1; b <= 6; b++) begin
      wr_reg(OFF_CLK_DIV_CTRL, 8'h01 | (8'h01 << b));
      gap(b - 1, g); `CHK(g, 12);
      gap(b == 1 ? 1 : 0, g); `CHK(g, 6);
    end
    gap(6, g); `CHK(g, 6);
    for (int m = 0; m < 4; m++) begin
      serial_mode_i <= 2'(m);
      gap(3, g); `CHK(g, m[0] ? 0 : 6);
    end
    nonvolatile_double_speed_bit_i <= 1'b1;
    wr_reg(OFF_CLK_DIV_CTRL, 8'h00);
    cyc(2); `CHK(cpu_fast_o, 1'b1);
    nonvolatile_double_speed_bit_i <= 1'b0;
    // Clock-out with a reload span of two steps
    wr_reg(OFF_TC_RELOAD_LO, 8'hFE);
    wr_reg(OFF_TC_RELOAD_HI, 8'hFF);
    wr_reg(OFF_TC_MODE, 8'h02);
    wr_reg(OFF_TC_CTRL, 8'h04);
    gap(8, g); `CHK(g, 8);
    wr_reg(OFF_CLK_DIV_CTRL, 8'h01);
    gap(8, g); `CHK(g, 4);
    gap(7, g); `CHK(g, 2);
    `CHK(seen_irq, 1'b0);
    wr_reg(OFF_TC_CTRL, 8'h00);
    gap(8, g); `CHK(g, 0);
    // Idle keeps peripherals running and ends on an interrupt
    wr_reg(OFF_POWER_CTRL, 8'h01);
    cyc(2); `CHK({cpu_halt_o, osc_run_o}, 2'h3);
    `CHK(strobes_o[4:1], 4'hC);
    gap(1, g); `CHK(g, 6);
    irq_pending_i <= 1'b1;
    cyc(3); `CHK(cpu_halt_o, 1'b0);
    irq_pending_i <= 1'b0;
    // Power-down stops the oscillator, the wake pin restarts it
    wr_reg(OFF_POWER_CTRL, 8'h02);
    cyc(2); `CHK({cpu_halt_o, osc_run_o, strobes_o.level}, 3'h4);
    irq_a_wake_en_i <= 1'b1;
    @(posedge mclk_i) wake_req <= 1'b1;
    @(posedge mclk_i) wake_req <= 1'b0;
    cyc(5); `CHK({cpu_halt_o, osc_run_o}, 2'h3);
    for (int k = 0; k < 100 && wake_irq_o !== 1'b1; k++) @(negedge mclk_i);
    `CHK(wake_irq_o, 1'b1);
    cyc(2); `CHK(cpu_halt_o, 1'b0);
    rd_chk(OFF_CLK_DIV_CTRL, 8'h01);
    // Reset from idle with the strap low and the latch strobe low
    wr_reg(OFF_POWER_CTRL, 8'h01);
    cyc(3);
    {external_access_select_i, addr_latch_strobe_i} <= 2'h0;
    @(posedge mclk_i) rst_req <= 1'b1;
    @(posedge mclk_i) rst_req <= 1'b0;
    #1 `CHK(port_reset_o, 1'b1);
    cyc(1); `CHK(ram_block_o, 1'b1);
    cyc(34); `CHK(internal_reset_o, 1'b1);
    wait_rel();
    {external_access_select_i, addr_latch_strobe_i} <= 2'h3;
    cyc(3); `CHK(external_program_o, 1'b1);
    `CHK({strobes_o.port0_float, strobes_o.weak_pullup}, 2'h3);
    `CHK(osc_run_o, 1'b1);
    rd_chk(OFF_POWER_CTRL, 8'h00);
    rd_chk(OFF_CLK_DIV_CTRL, CDC_RESET);
    end_sim();
  end
endmodule : clock_power_control_tb
`default_nettype wire
